// ### pwm_timer_defines.vh
/*
 Constants for the dual 12-bit autoreload PWM timer: register offsets,
 field positions, reset values and counter constants.
 Assumes inclusion by bare name from the timer design files.
*/
`ifndef PWM_TIMER_DEFINES_VH
`define PWM_TIMER_DEFINES_VH

// ==========================================================
// Register word offsets (byte address = 4 x index)
// ==========================================================
`define REG_CTRL       4'h0
`define REG_CTRL2      4'h1
`define REG_RELOAD1    4'h2
`define REG_RELOAD2    4'h3
`define REG_DUTY0      4'h4
`define REG_DUTY1      4'h5
`define REG_DUTY2      4'h6
`define REG_DUTY3      4'h7
`define REG_OUTCTRL    4'h8
`define REG_CHCTRL     4'h9
`define REG_BRKCTRL    4'hA
`define REG_BRKSCOPE   4'hB
`define REG_DEADTIME   4'hC
`define REG_CAPTURE    4'hD
`define REG_COUNTERS   4'hE

// ==========================================================
// Field positions
// ==========================================================
`define CTRL_CAP_FLAG  6
`define CTRL_CAP_IE    5
`define CTRL_CK_HI     4
`define CTRL_CK_LO     3
`define CTRL_OVF1      2
`define CTRL_CMP_IE    0
`define CTRL2_ENC2     0
`define CTRL2_TRAN1    1
`define CTRL2_TRAN2    2
`define CTRL2_FORCE_OVERFLOW_ONE   3
`define CTRL2_FORCE_OVERFLOW_TWO   4
`define CTRL2_CAPSRC   5
`define CTRL2_OVERFLOW_FLAG_TWO     6
`define BRK_LEVEL      6
`define BRK_ACTIVE     5
`define BRK_PIN_EN     4
`define DT_ENABLE      7

// ==========================================================
// Values
// ==========================================================
`define CNT_MAX        12'hFFF
`define CNT_ZERO       12'h000
`define CK_LITE        2'h1
`define CK_CPU         2'h2
`define BUS_DEFAULT    32'h0000_0000

`endif

// ### sync3.v
/*
 Three-stage synchroniser with agreement filter for one pin.
 Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ps
`include "pwm_timer_defines.vh"
module sync3 (
   input  wire clk,
   input  wire arst_n,
   input  wire pin,
   output reg  level_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q    <= 1'b0;
         s2_q    <= 1'b0;
         s3_q    <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end
endmodule

// ### dead_time_gen.v
/*
 Dead-time pair generator for outputs 0 and 1.
 Assumes one-cycle rise/fall strobes of the raw channel-0 waveform.
*/
`timescale 1ns/1ps
`include "pwm_timer_defines.vh"
module dead_time_gen (
   input  wire       clk,
   input  wire       arst_n,
   input  wire       hold,
   input  wire       rise,
   input  wire       fall,
   input  wire [6:0] count,
   output reg        out0_q,
   output reg        out1_q
);
   reg [6:0] delay_q;
   reg       pend_rise_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         delay_q     <= 7'h00;
         pend_rise_q <= 1'b0;
         out0_q      <= 1'b0;
         out1_q      <= 1'b0;
      end else if (hold) begin
         delay_q     <= 7'h00;
         pend_rise_q <= 1'b0;
         out0_q      <= 1'b0;
         out1_q      <= 1'b0;
      end else if (fall) begin
         out0_q      <= 1'b0;
         delay_q     <= count;
         pend_rise_q <= 1'b0;
      end else if (rise) begin
         out1_q      <= 1'b0;
         delay_q     <= count;
         pend_rise_q <= 1'b1;
      end else if (delay_q != 7'h00) begin
         delay_q <= delay_q - 7'h01;
         if (delay_q == 7'h01) begin
            if (pend_rise_q) begin
               out0_q <= 1'b1;
            end else begin
               out1_q <= 1'b1;
            end
         end
      end
   end
endmodule

// ### pwm_timer.v
/*
 Dual 12-bit autoreload PWM timer: dead time, break, compare, capture,
 one-pulse mode and forced overflow, with an Avalon-MM slave.
 Assumes a single 100 MHz clock; pins are asynchronous.
*/
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "pwm_timer_defines.vh"
module pwm_timer (
   input  wire        ref_clk,
   input  wire        arst_n,
   input  wire [5:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire        break_pin,
   input  wire        timer_capture_input,
   input  wire        lite_trigger_input,
   input  wire        lite_tick,
   output reg  [3:0]  pwm_out_q,
   output reg  [3:0]  pwm_oe_q,
   output reg         irq_q
);
   // ==========================================================
   // Helpers
   // ==========================================================
   function [11:0] wr12;
      input [11:0] old;
      input [31:0] d;
      input [3:0]  be;
      begin
         wr12 = {be[1] ? d[11:8] : old[11:8], be[0] ? d[7:0] : old[7:0]};
      end
   endfunction

   function hit;
      input [11:0] cnt;
      input [11:0] duty;
      begin
         hit = (duty != `CNT_ZERO) && (cnt == duty);
      end
   endfunction

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   wire brk_s;
   wire cap_s;
   wire lite_s;
   wire tick_s;
   sync3 u_sb (.clk(ref_clk), .arst_n(arst_n), .pin(break_pin),           .level_q(brk_s));
   sync3 u_sc (.clk(ref_clk), .arst_n(arst_n), .pin(timer_capture_input), .level_q(cap_s));
   sync3 u_sl (.clk(ref_clk), .arst_n(arst_n), .pin(lite_trigger_input),  .level_q(lite_s));
   sync3 u_st (.clk(ref_clk), .arst_n(arst_n), .pin(lite_tick),           .level_q(tick_s));

   // ==========================================================
   // Registers
   // ==========================================================
   reg        cap_flag_q, cap_ie_q, ovf1_q, ovf1_ie_q, cmp_ie_q;
   reg [1:0]  ck_sel_q;
   reg        enc2_q, tran1_q, tran2_q, force_overflow_one_q, force_overflow_two_q, cap_src_q, overflow_flag_two_q;
   reg [11:0] reload1_q, reload2_q, cnt1_q, cnt2_q, capture_q;
   reg [11:0] pre_q [0:3];
   reg [11:0] act_q [0:3];
   reg [3:0]  output_enable_q, pol_pre_q, pol_act_q, cmp_flag_q;
   reg        one_pulse_enable_q, op_edge_q;
   reg        brk_level_q, brk_active_q, brk_pin_en_q;
   reg [3:0]  brk_pattern_q;
   reg        brk_en1_q, brk_en2_q;
   reg [7:0]  dt_pre_q, dt_act_q;
   reg        cap_prev_q, lite_prev_q, tick_prev_q;
   reg        armed_q;
   reg [3:0]  wave_q;
   reg        wave0_prev_q;
   integer    i;
   integer    k;

   // ==========================================================
   // Bus decode
   // ==========================================================
   wire [3:0] idx   = avs_address[5:2];
   wire       acc   = (avs_read || avs_write) && avs_waitrequest;
   wire       wr    = acc && avs_write;
   wire       rd    = acc && avs_read;

   // ==========================================================
   // Counter clocking and events
   // ==========================================================
   wire tick    = (ck_sel_q == `CK_CPU) || ((ck_sel_q == `CK_LITE) && tick_s && !tick_prev_q);
   wire brk_lvl = brk_pin_en_q && (brk_s == brk_level_q);
   wire brk_on  = brk_active_q || brk_lvl;
   wire brk_c1  = brk_on && brk_en1_q;
   wire brk_c2  = brk_on && (enc2_q ? brk_en2_q : brk_en1_q);
   wire op_mode = one_pulse_enable_q && enc2_q;
   wire l_edge  = op_edge_q ? (lite_s && !lite_prev_q) : (!lite_s && lite_prev_q);
   wire trig    = op_mode && l_edge && armed_q;
   wire [11:0] c2eff = enc2_q ? cnt2_q : cnt1_q;
   wire ovf1 = tick && (cnt1_q == `CNT_MAX) && !brk_c1;
   wire overflow_flag_two = enc2_q && tick && (cnt2_q == `CNT_MAX) && !brk_c2;
   wire op_wrap = op_mode && tick && (cnt2_q == reload2_q) && !brk_c2;
   wire ovf_b = enc2_q ? (overflow_flag_two || trig || op_wrap) : ovf1;
   wire cap_src = (ck_sel_q == `CK_LITE && cap_src_q) ? lite_s : cap_s;
   wire cap_ev  = (cap_src != cap_prev_q) && !cap_flag_q;

   // ==========================================================
   // Sequential core
   // ==========================================================
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cap_flag_q <= 1'b0; cap_ie_q <= 1'b0; ovf1_q <= 1'b0;
         ovf1_ie_q <= 1'b0; cmp_ie_q <= 1'b0; ck_sel_q <= 2'h0;
         enc2_q <= 1'b0; tran1_q <= 1'b0; tran2_q <= 1'b0;
         force_overflow_one_q <= 1'b0; force_overflow_two_q <= 1'b0; cap_src_q <= 1'b0; overflow_flag_two_q <= 1'b0;
         reload1_q <= `CNT_ZERO; reload2_q <= `CNT_ZERO;
         cnt1_q <= `CNT_ZERO; cnt2_q <= `CNT_ZERO; capture_q <= `CNT_ZERO;
         for (i = 0; i < 4; i = i + 1) begin
            pre_q[i] <= `CNT_ZERO;
            act_q[i] <= `CNT_ZERO;
         end
         output_enable_q <= 4'h0; pol_pre_q <= 4'h0; pol_act_q <= 4'h0;
         cmp_flag_q <= 4'h0; one_pulse_enable_q <= 1'b0; op_edge_q <= 1'b0;
         brk_level_q <= 1'b0; brk_active_q <= 1'b0; brk_pin_en_q <= 1'b0;
         brk_pattern_q <= 4'h0; brk_en1_q <= 1'b0; brk_en2_q <= 1'b0;
         dt_pre_q <= 8'h00; dt_act_q <= 8'h00;
         cap_prev_q <= 1'b0; lite_prev_q <= 1'b0;
         tick_prev_q <= 1'b0; armed_q <= 1'b0; wave_q <= 4'h0;
         avs_readdata <= `BUS_DEFAULT; avs_waitrequest <= 1'b1;
      end else begin
         cap_prev_q  <= cap_src;
         lite_prev_q <= lite_s;
         tick_prev_q <= tick_s;
         avs_waitrequest <= !(avs_read || avs_write) || !avs_waitrequest;

         // Software writes first; hardware events below win over clears
         if (wr) begin
            case (idx)
               `REG_CTRL: if (avs_byteenable[0]) begin
                  cap_ie_q <= avs_writedata[`CTRL_CAP_IE];
                  ck_sel_q <= avs_writedata[`CTRL_CK_HI:`CTRL_CK_LO];
                  ovf1_ie_q <= avs_writedata[1];
                  cmp_ie_q <= avs_writedata[`CTRL_CMP_IE];
               end
               `REG_CTRL2: if (avs_byteenable[0]) begin
                  enc2_q    <= avs_writedata[`CTRL2_ENC2];
                  tran1_q   <= avs_writedata[`CTRL2_TRAN1];
                  tran2_q   <= avs_writedata[`CTRL2_TRAN2];
                  force_overflow_one_q  <= force_overflow_one_q | avs_writedata[`CTRL2_FORCE_OVERFLOW_ONE];
                  force_overflow_two_q  <= force_overflow_two_q | avs_writedata[`CTRL2_FORCE_OVERFLOW_TWO];
                  cap_src_q <= avs_writedata[`CTRL2_CAPSRC];
               end
               `REG_RELOAD1: reload1_q <= wr12(reload1_q, avs_writedata, avs_byteenable);
               `REG_RELOAD2: reload2_q <= wr12(reload2_q, avs_writedata, avs_byteenable);
               `REG_DUTY0, `REG_DUTY1, `REG_DUTY2, `REG_DUTY3:
                  pre_q[idx[1:0]] <= wr12(pre_q[idx[1:0]], avs_writedata, avs_byteenable);
               `REG_OUTCTRL: if (avs_byteenable[0]) output_enable_q <= avs_writedata[3:0];
               `REG_CHCTRL: if (avs_byteenable[0]) begin
                  pol_pre_q <= avs_writedata[3:0];
                  one_pulse_enable_q   <= avs_writedata[4];
                  op_edge_q <= avs_writedata[5];
               end
               `REG_BRKCTRL: if (avs_byteenable[0]) begin
                  brk_level_q   <= avs_writedata[`BRK_LEVEL];
                  brk_active_q  <= avs_writedata[`BRK_ACTIVE];
                  brk_pin_en_q  <= avs_writedata[`BRK_PIN_EN];
                  brk_pattern_q <= avs_writedata[3:0];
               end
               `REG_BRKSCOPE: if (avs_byteenable[0]) begin
                  brk_en1_q <= avs_writedata[0];
                  brk_en2_q <= avs_writedata[1];
               end
               `REG_DEADTIME: if (avs_byteenable[0]) dt_pre_q <= avs_writedata[7:0];
               default: ;
            endcase
         end

         if (rd) begin
            case (idx)
               `REG_CTRL: avs_readdata <= {25'h0, cap_flag_q, cap_ie_q, ck_sel_q,
                                           ovf1_q, ovf1_ie_q, cmp_ie_q};
               `REG_CTRL2: avs_readdata <= {25'h0, overflow_flag_two_q, cap_src_q, force_overflow_two_q,
                                            force_overflow_one_q, tran2_q, tran1_q, enc2_q};
               `REG_RELOAD1: avs_readdata <= {20'h0, reload1_q};
               `REG_RELOAD2: avs_readdata <= {20'h0, reload2_q};
               `REG_DUTY0, `REG_DUTY1, `REG_DUTY2, `REG_DUTY3:
                  avs_readdata <= {20'h0, pre_q[idx[1:0]]};
               `REG_OUTCTRL: avs_readdata <= {28'h0, output_enable_q};
               `REG_CHCTRL: avs_readdata <= {22'h0, op_edge_q, one_pulse_enable_q, cmp_flag_q, pol_pre_q};
               `REG_BRKCTRL: avs_readdata <= {25'h0, brk_level_q, brk_active_q,
                                              brk_pin_en_q, brk_pattern_q};
               `REG_BRKSCOPE: avs_readdata <= {30'h0, brk_en2_q, brk_en1_q};
               `REG_DEADTIME: avs_readdata <= {24'h0, dt_pre_q};
               `REG_CAPTURE: avs_readdata <= {20'h0, capture_q};
               `REG_COUNTERS: avs_readdata <= {4'h0, cnt2_q, 4'h0, cnt1_q};
               default: avs_readdata <= `BUS_DEFAULT;
            endcase
            if (idx == `REG_CTRL) ovf1_q <= 1'b0;
            if (idx == `REG_CTRL2) overflow_flag_two_q <= 1'b0;
            if (idx == `REG_CHCTRL) cmp_flag_q <= 4'h0;
            if (idx == `REG_CAPTURE) cap_flag_q <= 1'b0;
         end

         if (brk_lvl) brk_active_q <= 1'b1;

         // Counter 1
         if (brk_c1) begin
            cnt1_q <= `CNT_ZERO;
         end else if (force_overflow_one_q) begin
            cnt1_q   <= `CNT_MAX;
            force_overflow_one_q <= 1'b0;
         end else if (tick) begin
            cnt1_q <= ovf1 ? reload1_q : cnt1_q + 12'h001;
         end
         if (ovf1) begin
            ovf1_q   <= 1'b1;
            dt_act_q <= dt_pre_q;
            if (tran1_q) begin
               act_q[0] <= pre_q[0];
               act_q[1] <= pre_q[1];
               pol_act_q[1:0] <= pol_pre_q[1:0];
               if (!enc2_q) begin
                  act_q[2] <= pre_q[2];
                  act_q[3] <= pre_q[3];
                  pol_act_q[3:2] <= pol_pre_q[3:2];
               end
            end
         end

         // Counter 2 (channels 2 and 3), in priority order
         if (brk_c2) begin
            cnt2_q <= `CNT_ZERO;
         end else if (trig) begin
            cnt2_q <= `CNT_ZERO;
         end else if (force_overflow_two_q && enc2_q) begin
            cnt2_q   <= `CNT_MAX;
            force_overflow_two_q <= 1'b0;
         end else if (op_wrap) begin
            cnt2_q <= `CNT_ZERO;
         end else if (enc2_q && tick) begin
            cnt2_q <= overflow_flag_two ? (op_mode ? `CNT_ZERO : reload2_q) : cnt2_q + 12'h001;
         end
         if (enc2_q && (overflow_flag_two || trig || op_wrap)) overflow_flag_two_q <= 1'b1;
         if (enc2_q && ovf_b && tran2_q) begin
            act_q[2] <= pre_q[2];
            act_q[3] <= pre_q[3];
            pol_act_q[3:2] <= pol_pre_q[3:2];
         end

         if (trig) armed_q <= 1'b0;
         else if (hit(cnt2_q, act_q[3])) armed_q <= 1'b1;
         if (!op_mode) armed_q <= 1'b1;

         // Compare flags and raw waves
         for (i = 0; i < 4; i = i + 1) begin
            if (hit(i < 2 ? cnt1_q : c2eff, act_q[i])) begin
               cmp_flag_q[i] <= 1'b1;
               wave_q[i]     <= 1'b0;
            end
         end
         if (ovf1) wave_q[1:0] <= 2'h3;
         if (enc2_q ? ovf_b : ovf1) wave_q[3:2] <= 2'h3;

         // Capture
         if (cap_ev) begin
            capture_q  <= cnt1_q;
            cap_flag_q <= 1'b1;
         end

         if (brk_on) begin
            reload1_q <= `CNT_ZERO;
            reload2_q <= `CNT_ZERO;
            for (i = 0; i < 4; i = i + 1) begin
               pre_q[i] <= `CNT_ZERO;
               act_q[i] <= `CNT_ZERO;
            end
         end
      end
   end

   // ==========================================================
   // Dead time on outputs 0 and 1
   // ==========================================================
   wire dt_use  = dt_act_q[`DT_ENABLE] && (dt_act_q[6:0] != 7'h00);
   wire dt_hold = dt_act_q[`DT_ENABLE] && (dt_act_q[6:0] == 7'h00);
   wire dt0;
   wire dt1;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) wave0_prev_q <= 1'b0;
      else wave0_prev_q <= wave_q[0];
   end
   dead_time_gen u_dt (
      .clk    (ref_clk),
      .arst_n (arst_n),
      .hold   (!dt_use),
      .rise   (wave_q[0] && !wave0_prev_q),
      .fall   (!wave_q[0] && wave0_prev_q),
      .count  (dt_act_q[6:0]),
      .out0_q (dt0),
      .out1_q (dt1)
   );

   // ==========================================================
   // Output stage
   // ==========================================================
   reg [3:0] raw;
   reg [3:0] gated;
   always @* begin
      raw = wave_q;
      if (dt_use) raw[1:0] = {dt1, dt0};
      raw = raw ^ pol_act_q;
      if (dt_hold) raw[1:0] = 2'h0;
      gated = raw;
      for (k = 0; k < 4; k = k + 1) begin
         if ((k < 2 ? brk_c1 : brk_c2) && output_enable_q[k])
            gated[k] = brk_pattern_q[k];
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pwm_out_q <= 4'h0;
         pwm_oe_q  <= 4'h0;
         irq_q     <= 1'b0;
      end else begin
         pwm_out_q <= gated & output_enable_q;
         pwm_oe_q  <= output_enable_q;
         irq_q     <= (cmp_ie_q && (cmp_flag_q != 4'h0))
                    || (cap_ie_q && cap_flag_q)
                    || (ovf1_ie_q && ovf1_q);
      end
   end
endmodule

// ### pwm_timer_monitor.sv
/* Port checker for the PWM timer.
   Assumes it is bound to pwm_timer and sees only its ports. */
`timescale 1ns/1ps
module pwm_timer_monitor (
   input wire        ref_clk,
   input wire        arst_n,
   input wire [5:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire        break_pin,
   input wire        timer_capture_input,
   input wire        lite_trigger_input,
   input wire        lite_tick,
   input wire [3:0]  pwm_out_q,
   input wire [3:0]  pwm_oe_q,
   input wire        irq_q
);
   // ==========================================================
   // Bus and output checks
   wire oe_wr = avs_write && avs_waitrequest && avs_address == 6'h20 && avs_byteenable[0];
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_answer; !avs_waitrequest ##1 avs_waitrequest; endsequence
   property p_answer; s_req |=> s_answer; endproperty
   a_answer: assert property (p_answer) else $error("bus answer missing");
   property p_idle; !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("answer without request");
   property p_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
   a_cause: assert property (p_cause) else $error("answer without cause");
   property p_rd_hold; avs_waitrequest |-> $stable(avs_readdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_unmapped;
      avs_read && avs_waitrequest && avs_address[5:2] == 4'hF |=> avs_readdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_oe_wr; oe_wr |-> ##2 pwm_oe_q == $past(avs_writedata[3:0], 2); endproperty
   a_oe_wr: assert property (p_oe_wr) else $error("enable not written");
   property p_oe_hold; !oe_wr |-> ##2 $stable(pwm_oe_q); endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("enable changed alone");
   property p_off_low; (~pwm_oe_q & ~$past(pwm_oe_q) & pwm_out_q) == 4'h0; endproperty
   a_off_low: assert property (p_off_low) else $error("disabled output high");
endmodule
bind pwm_timer pwm_timer_monitor i_mon (.ref_clk, .arst_n, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
   .break_pin, .timer_capture_input, .lite_trigger_input, .lite_tick, .pwm_out_q,
   .pwm_oe_q, .irq_q);

// ### stage_model.sv
/* Pin model: fault line, capture source and lite time base.
   Assumes the bench drives fault and cap_lvl. */
`timescale 1ns/1ps
module stage_model (
   input  wire ref_clk,
   input  wire arst_n,
   input  wire fault,
   input  wire cap_lvl,
   output wire break_pin,
   output wire cap_pin,
   output wire lite_pin,
   output wire lite_tick
);
   reg [1:0] div_q;
   // Fault pulls the line low
   assign break_pin = !fault;
   assign cap_pin   = cap_lvl;
   assign lite_pin  = cap_lvl;
   assign lite_tick = div_q[1];
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         div_q <= 2'h0;
      else
         div_q <= div_q + 2'h1;
   end
endmodule

// ### dual_autoreload_pwm_timer_ext_bench.sv
/* Self-checking bench for the PWM timer.
   Assumes a 100 MHz clock and the stage_model pin model. */
`timescale 1ns/1ps
module dual_autoreload_pwm_timer_ext_bench;
   reg         ref_clk;
   reg         arst_n;
   reg  [5:0]  avs_address;
   reg         avs_read;
   reg         avs_write;
   reg  [31:0] avs_writedata;
   reg  [3:0]  avs_byteenable;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest;
   wire        break_pin;
   wire        cap_pin;
   wire        lite_pin;
   wire        lite_tick;
   wire [3:0]  pwm_out_q;
   wire [3:0]  pwm_oe_q;
   wire        irq_q;
   reg         fault;
   reg         cap_lvl;
   reg  [31:0] rd;
   integer     n_mismatch;
   integer     tests_run;
   pwm_timer i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .break_pin(break_pin),
      .timer_capture_input(cap_pin), .lite_trigger_input(lite_pin),
      .lite_tick(lite_tick), .pwm_out_q(pwm_out_q), .pwm_oe_q(pwm_oe_q), .irq_q(irq_q));
   stage_model i_stage (.ref_clk(ref_clk), .arst_n(arst_n), .fault(fault),
      .cap_lvl(cap_lvl), .break_pin(break_pin), .cap_pin(cap_pin),
      .lite_pin(lite_pin), .lite_tick(lite_tick));
   // ==========================================================
   // Shared tasks
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", tests_run, n_mismatch);
         if (n_mismatch == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task chk(input ok, input [8*20:1] msg);
      begin
         tests_run = tests_run + 1;
         if (ok !== 1'b1) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %0t %0s", $time, msg);
         end
      end
   endtask
   task xfer(input rdn, input [5:0] a, input [31:0] d);
      integer i;
      begin
         @(posedge ref_clk);
         avs_address <= a;
         avs_writedata <= d;
         avs_read <= rdn;
         avs_write <= !rdn;
         for (i = 0; i < 20 && avs_waitrequest !== 1'b0; i = i + 1)
            @(posedge ref_clk);
         rd = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         chk(i < 20, "bus timeout");
         if (i == 20)
            end_sim;
      end
   endtask
   // ==========================================================
   // Scenarios
   task t_reset;
      begin
         xfer(1, 6'h00, 0);
         chk(rd === 32'h0, "ctrl reset");
         xfer(1, 6'h3C, 0);
         chk(rd === 32'h0, "unmapped read");
      end
   endtask
   task t_compare;
      begin
         xfer(0, 6'h08, 32'hFF0);
         xfer(0, 6'h10, 32'hFF8);
         xfer(0, 6'h18, 32'hFF4);
         xfer(0, 6'h00, 32'h11);
         xfer(0, 6'h04, 32'h0A);
         repeat (40) @(posedge ref_clk);
         chk(irq_q === 1'b1, "compare irq");
         xfer(1, 6'h04, 0);
         chk(rd[3] === 1'b0, "force not cleared");
         xfer(1, 6'h24, 0);
         chk(rd[7:4] === 4'h5, "compare flags");
         xfer(1, 6'h38, 0);
         chk(rd[11:4] === 8'hFF, "reload range");
      end
   endtask
   task t_capture;
      begin
         xfer(0, 6'h00, 32'h31);
         cap_lvl <= 1'b1;
         repeat (10) @(posedge ref_clk);
         xfer(1, 6'h00, 0);
         chk(rd[6] === 1'b1, "capture flag");
         xfer(1, 6'h34, 0);
         chk(rd[11:4] === 8'hFF, "capture value");
         xfer(1, 6'h00, 0);
         chk(rd[6] === 1'b0, "flag not cleared");
      end
   endtask
   task t_soft_break;
      begin
         xfer(0, 6'h20, 32'hF);
         xfer(0, 6'h2C, 32'h1);
         xfer(0, 6'h28, 32'h2A);
         repeat (4) @(posedge ref_clk);
         chk(pwm_out_q === 4'hA, "soft break pattern");
         xfer(1, 6'h38, 0);
         chk(rd[11:0] === 12'h000, "counter not cleared");
         xfer(1, 6'h10, 0);
         chk(rd[11:0] === 12'h000, "duty not cleared");
         xfer(0, 6'h28, 32'h0);
         repeat (20) @(posedge ref_clk);
         xfer(1, 6'h38, 0);
         chk(rd[11:0] !== 12'h000, "counting not back");
      end
   endtask
   task t_pin_break;
      begin
         fault <= 1'b1;
         xfer(0, 6'h28, 32'h05);
         repeat (10) @(posedge ref_clk);
         xfer(1, 6'h28, 0);
         chk(rd[5] === 1'b0, "break without pin en");
         xfer(0, 6'h28, 32'h15);
         repeat (10) @(posedge ref_clk);
         xfer(1, 6'h28, 0);
         chk(rd[5] === 1'b1, "pin break missed");
         chk(pwm_out_q === 4'h5, "pin break pattern");
         fault <= 1'b0;
         repeat (10) @(posedge ref_clk);
         xfer(0, 6'h28, 32'h0);
         xfer(1, 6'h28, 0);
         chk(rd[5] === 1'b0, "break not released");
      end
   endtask
   task t_dead_time;
      integer k;
      integer n_low;
      integer n_both;
      begin
         xfer(0, 6'h08, 32'hFF0);
         xfer(0, 6'h10, 32'hFF8);
         xfer(0, 6'h30, 32'h82);
         xfer(0, 6'h04, 32'h0A);
         repeat (24) @(posedge ref_clk);
         n_low = 0;
         n_both = 0;
         for (k = 0; k < 64; k = k + 1) begin
            @(posedge ref_clk);
            if (pwm_out_q[1:0] === 2'h0)
               n_low = n_low + 1;
            if (pwm_out_q[1] !== 1'b0 && pwm_out_q[0] !== 1'b0)
               n_both = n_both + 1;
         end
         chk(n_both == 0, "outputs overlap");
         chk(n_low == 16, "dead time length");
         xfer(0, 6'h30, 32'h80);
         xfer(0, 6'h04, 32'h0A);
         repeat (8) @(posedge ref_clk);
         n_both = 0;
         for (k = 0; k < 32; k = k + 1) begin
            @(posedge ref_clk);
            if (pwm_out_q[1:0] !== 2'h0)
               n_both = n_both + 1;
         end
         chk(n_both == 0, "zero count not held");
      end
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      arst_n = 1'b0;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      fault = 1'b0;
      cap_lvl = 1'b0;
      n_mismatch = 0;
      tests_run = 0;
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_reset;
      t_compare;
      t_capture;
      t_soft_break;
      t_pin_break;
      t_dead_time;
      end_sim;
   end
endmodule
